//--- include/fcct_regs.svh
/*
 * Register map, field positions, reset values and timing constants of the
 * four-channel capture/compare timer.
 * Assumes word addressing on a 5-bit register port with 16-bit data.
 */
`ifndef FCCT_REGS_SVH
`define FCCT_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FCCT_A_CTRL 5'h00
`define FCCT_A_IOS 5'h01
`define FCCT_A_OUTCTL 5'h02
`define FCCT_A_EDGE 5'h03
`define FCCT_A_FORCE 5'h04
`define FCCT_A_CH3 5'h05
`define FCCT_A_IRQEN 5'h06
`define FCCT_A_FLAGS 5'h07
`define FCCT_A_COUNT 5'h08
`define FCCT_A_CMP0 5'h09
`define FCCT_A_PACTL 5'h0d
`define FCCT_A_PAFLG 5'h0e
`define FCCT_A_PACNT 5'h0f
`define FCCT_A_PORT 5'h10
`define FCCT_A_DDR 5'h11

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FCCT_CTRL_EN 0
`define FCCT_CTRL_FFC 1
`define FCCT_CTRL_COUNTER_RESET_ON_CH3 2
`define FCCT_CTRL_PS_LO 4
`define FCCT_PACTL_MODE 0
`define FCCT_PACTL_POL 1
`define FCCT_PACTL_EN 2
`define FCCT_IRQEN_PAI 4
`define FCCT_IRQEN_PAOV 5

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define FCCT_RST16 16'h0000
`define FCCT_PS_MAX 3'h4
`define FCCT_DIV64_LAST 6'h3f
`define FCCT_PA_TOP 16'hffff
`endif

//--- include/fcct_pkg.sv
/*
 * Types shared by the capture/compare timer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fcct_pkg;
    // Compare output action, mode bit high, level bit low
    typedef enum logic [1:0] {
        FCCT_ACT_OFF = 2'h0,
        FCCT_ACT_TGL = 2'h1,
        FCCT_ACT_CLR = 2'h2,
        FCCT_ACT_SET = 2'h3
    } fcct_act_t;
endpackage : fcct_pkg

//--- hdl/fcct_timer.sv
/*
 * Four-channel 16-bit capture/compare timer with pulse accumulator,
 * channel-3 override and masked port transfer, on a plain register port.
 * Assumes pins are synchronous to i_clk and the pad wire is resolved from
 * o_pin_out and o_pin_oe outside.
 */
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "fcct_regs.svh"

// Function
// - 16-bit counter, four capture/compare channels and a pulse accumulator.
// - Counter advances on module clock divided by prescaler picked by 3 bits.
// - Capture channel copies counter to its register on an active pin edge if its direction bit is clear.
// - Capture or compare sets channel flag; enabled flag requests interrupt.
// - Compare match sets, clears or toggles the pin per mode and level.
// - Mode and level both zero disconnect the pin from compare logic unless its channel-3 mask bit is set.
// - Force bit does compare action now without setting the flag.
// - Channel-3 compare overrides the compare outputs of masked compare channels.
// - Channel-3 compare copies masked channel-3 data bits into port data.
// - Counter reset on channel 3 clears counter, even in accumulator use.
// - Compare channel drives pin regardless of direction bit, left unchanged.
// - Port write to compare-owned pin only updates latch, shown later.
// - 16-bit accumulator; mode bit selects event or gated counting.
// - Event mode counts active edges and sets input flag; polarity picks edge.
// - Accumulator input flag requests interrupt when its enable is set.
// - Wrap from ffff to 0000 sets overflow flag; enabled it requests.
// - Event counting continues while timer enable bit is clear.
// - Gated mode counts divide-by-64 pulses while input at active level.
// - Gated mode sets input flag at trailing edge of active level.
// - Divide-by-64 pulses come from prescaler and stop with the timer.
// - Flags clear by writing one; zero leaves them.
// - With fast clear, any accumulator count access clears both its flags.
module fcct_timer #(
    parameter int NCH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [NCH-1:0] i_pin,
    output logic [NCH-1:0] o_pin_out,
    output logic [NCH-1:0] o_pin_oe,
    output logic [NCH+1:0] o_irq
);
    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic wr_at(input logic [4:0] a);
        return i_wr && (i_addr == a);
    endfunction : wr_at

    function automatic logic edge_hit(input logic [1:0] cfg,
                                      input logic prev, input logic cur);
        return (cfg[0] && !prev && cur) || (cfg[1] && prev && !cur);
    endfunction : edge_hit

    function automatic logic act_apply(input fcct_pkg::fcct_act_t act,
                                       input logic cur);
        unique case (act)
            fcct_pkg::FCCT_ACT_OFF: return cur;
            fcct_pkg::FCCT_ACT_TGL: return !cur;
            fcct_pkg::FCCT_ACT_CLR: return 1'b0;
            fcct_pkg::FCCT_ACT_SET: return 1'b1;
        endcase
    endfunction : act_apply

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] ctrl_q, ctrl_d;
    logic [NCH-1:0] ios_q, ios_d, ddr_q, ddr_d, port_q, port_d;
    logic [2*NCH-1:0] outctl_q, outctl_d, edge_q, edge_d;
    logic [NCH-1:0] mask_q, mask_d, c3dat_q, c3dat_d;
    logic [NCH+1:0] irqen_q, irqen_d;
    logic [NCH-1:0] flag_q, flag_d, oc_q, oc_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] cmp_q [NCH];
    logic [15:0] cmp_d [NCH];
    logic [5:0] pre_q, pre_d;
    logic [2:0] pactl_q, pactl_d;
    logic [1:0] paflg_q, paflg_d;
    logic [15:0] pacnt_q, pacnt_d;
    logic [NCH-1:0] s1_q, s2_q, s3_q;
    logic [NCH-1:0] pout_q, poe_q;
    logic [15:0] rdata_q, rdata_d;

    logic en, tick, div64, counter_reset_on_ch3, ffc;
    logic [3:0] ps_mask;
    logic [NCH-1:0] cap, match, force_hit, owned;
    logic pa_now, pa_prev, pa_inc, pa_edge, pa_trail, pa_touch, pa_wr;

    assign en = ctrl_q[`FCCT_CTRL_EN];
    assign counter_reset_on_ch3 = ctrl_q[`FCCT_CTRL_COUNTER_RESET_ON_CH3];
    assign ffc = ctrl_q[`FCCT_CTRL_FFC];

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    // Select 0..4 gives divide by 1..16, higher codes stay at 16
    always_comb begin
        logic [2:0] sel;
        sel = ctrl_q[`FCCT_CTRL_PS_LO +: 3];
        if (sel >= `FCCT_PS_MAX) begin
            ps_mask = 4'hf;
        end else begin
            ps_mask = 4'((5'h01 << sel) - 5'h01);
        end
    end

    assign tick = en && ((pre_q[3:0] & ps_mask) == ps_mask);
    // Gate clock shares the prescaler so it dies with the timer
    assign div64 = en && (pre_q == `FCCT_DIV64_LAST);

    always_comb begin
        pre_d = en ? pre_q + 6'h01 : 6'h00;
        cnt_d = cnt_q;
        if (tick) begin
            cnt_d = cnt_q + 16'h0001;
        end
        if (wr_at(`FCCT_A_COUNT)) begin
            cnt_d = i_wdata; // Else a write is lost at divide by one
        end
        if (match[3] && counter_reset_on_ch3) begin
            cnt_d = 16'h0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pre_q <= 6'h00;
            cnt_q <= `FCCT_RST16;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and per-channel events
    // ------------------------------------------------------------------
    // Pulses shorter than one clock may slip through unseen
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            // Capture only on a pin set as input
            assign cap[g] = en && !ios_q[g] && !ddr_q[g] &&
                edge_hit(edge_q[2*g +: 2], s3_q[g], s2_q[g]);
            assign match[g] = tick && ios_q[g] &&
                (cnt_q == cmp_q[g]);
            assign force_hit[g] = wr_at(`FCCT_A_FORCE) && i_wdata[g] &&
                ios_q[g];
            // Pin belongs to compare logic unless off and unmasked
            assign owned[g] = en && ios_q[g] &&
                (outctl_q[2*g +: 2] != 2'h0 || mask_q[g]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Configuration, flags, compare registers and output latches
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_d = wr_at(`FCCT_A_CTRL) ? i_wdata : ctrl_q;
        ios_d = wr_at(`FCCT_A_IOS) ? i_wdata[NCH-1:0] : ios_q;
        ddr_d = wr_at(`FCCT_A_DDR) ? i_wdata[NCH-1:0] : ddr_q;
        outctl_d = wr_at(`FCCT_A_OUTCTL) ? i_wdata[2*NCH-1:0] : outctl_q;
        edge_d = wr_at(`FCCT_A_EDGE) ? i_wdata[2*NCH-1:0] : edge_q;
        mask_d = wr_at(`FCCT_A_CH3) ? i_wdata[NCH-1:0] : mask_q;
        c3dat_d = wr_at(`FCCT_A_CH3) ? i_wdata[2*NCH-1:NCH] : c3dat_q;
        irqen_d = wr_at(`FCCT_A_IRQEN) ? i_wdata[NCH+1:0] : irqen_q;
        // Port writes land in the latch only; owned pins ignore it
        port_d = wr_at(`FCCT_A_PORT) ? i_wdata[NCH-1:0] : port_q;
        if (match[3]) begin
            // Transfer beats a port write in the same cycle
            port_d = (port_d & ~mask_q) | (c3dat_q & mask_q);
        end
        // Hardware set wins over a write-one clear
        flag_d = flag_q;
        if (wr_at(`FCCT_A_FLAGS)) begin
            flag_d = flag_q & ~i_wdata[NCH-1:0];
        end
        flag_d = flag_d | cap | match;
        for (int n = 0; n < NCH; n++) begin
            cmp_d[n] = wr_at(5'(`FCCT_A_CMP0 + n)) ? i_wdata : cmp_q[n];
            if (cap[n]) begin
                cmp_d[n] = cnt_q;
            end
            oc_d[n] = oc_q[n];
            if (match[n] || force_hit[n]) begin
                oc_d[n] = act_apply(fcct_pkg::fcct_act_t'(
                    outctl_q[2*n +: 2]), oc_q[n]);
            end
            if (match[3] && mask_q[n] && ios_q[n]) begin
                oc_d[n] = c3dat_q[n];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_q <= `FCCT_RST16;
            ios_q <= '0;
            ddr_q <= '0;
            outctl_q <= '0;
            edge_q <= '0;
            mask_q <= '0;
            c3dat_q <= '0;
            irqen_q <= '0;
            port_q <= '0;
            flag_q <= '0;
            oc_q <= '0;
            for (int n = 0; n < NCH; n++) begin
                cmp_q[n] <= `FCCT_RST16;
            end
        end else begin
            ctrl_q <= ctrl_d;
            ios_q <= ios_d;
            ddr_q <= ddr_d;
            outctl_q <= outctl_d;
            edge_q <= edge_d;
            mask_q <= mask_d;
            c3dat_q <= c3dat_d;
            irqen_q <= irqen_d;
            port_q <= port_d;
            flag_q <= flag_d;
            oc_q <= oc_d;
            for (int n = 0; n < NCH; n++) begin
                cmp_q[n] <= cmp_d[n];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pulse accumulator on the channel-3 pin
    // ------------------------------------------------------------------
    // Polarity high means rising edge or high level is active
    assign pa_now = pactl_q[`FCCT_PACTL_POL] ? s2_q[3] : !s2_q[3];
    assign pa_prev = pactl_q[`FCCT_PACTL_POL] ? s3_q[3] : !s3_q[3];
    assign pa_edge = pactl_q[`FCCT_PACTL_EN] && !pactl_q[`FCCT_PACTL_MODE] &&
        pa_now && !pa_prev;
    assign pa_trail = pactl_q[`FCCT_PACTL_EN] &&
        pactl_q[`FCCT_PACTL_MODE] && pa_prev && !pa_now;
    assign pa_inc = pa_edge || (pactl_q[`FCCT_PACTL_EN] &&
        pactl_q[`FCCT_PACTL_MODE] && pa_now && div64);
    assign pa_wr = wr_at(`FCCT_A_PACNT);
    assign pa_touch = ffc && (i_wr || i_rd) && (i_addr == `FCCT_A_PACNT);

    always_comb begin
        pactl_d = wr_at(`FCCT_A_PACTL) ? i_wdata[2:0] : pactl_q;
        pacnt_d = pacnt_q;
        if (pa_inc) begin
            pacnt_d = pacnt_q + 16'h0001;
        end
        if (pa_wr) begin
            pacnt_d = i_wdata;
        end
        paflg_d = paflg_q;
        if (wr_at(`FCCT_A_PAFLG)) begin
            paflg_d = paflg_q & ~i_wdata[1:0];
        end
        if (pa_touch) begin
            paflg_d = 2'h0;
        end
        paflg_d[0] = paflg_d[0] || pa_edge || pa_trail;
        paflg_d[1] = paflg_d[1] ||
            (pa_inc && pacnt_q == `FCCT_PA_TOP);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pactl_q <= 3'h0;
            pacnt_q <= `FCCT_RST16;
            paflg_q <= 2'h0;
        end else begin
            pactl_q <= pactl_d;
            pacnt_q <= pacnt_d;
            paflg_q <= paflg_d;
        end
    end

    // ------------------------------------------------------------------
    // Pins, interrupt requests and read port
    // ------------------------------------------------------------------
    // Direction register is never altered by compare ownership
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pout_q <= '0;
            poe_q <= '0;
        end else begin
            poe_q <= owned | ddr_q;
            pout_q <= (owned & oc_q) | (~owned & port_q);
        end
    end

    assign o_pin_out = pout_q;
    assign o_pin_oe = poe_q;
    assign o_irq = {paflg_q, flag_q} & {irqen_q[`FCCT_IRQEN_PAOV],
        irqen_q[`FCCT_IRQEN_PAI], irqen_q[NCH-1:0]};

    always_comb begin
        rdata_d = 16'h0000;
        if (i_rd) begin
            unique case (i_addr)
                `FCCT_A_CTRL: rdata_d = ctrl_q;
                `FCCT_A_IOS: rdata_d[NCH-1:0] = ios_q;
                `FCCT_A_OUTCTL: rdata_d[2*NCH-1:0] = outctl_q;
                `FCCT_A_EDGE: rdata_d[2*NCH-1:0] = edge_q;
                `FCCT_A_CH3: rdata_d[2*NCH-1:0] = {c3dat_q, mask_q};
                `FCCT_A_IRQEN: rdata_d[NCH+1:0] = irqen_q;
                `FCCT_A_FLAGS: rdata_d[NCH-1:0] = flag_q;
                `FCCT_A_COUNT: rdata_d = cnt_q;
                `FCCT_A_PACTL: rdata_d[2:0] = pactl_q;
                `FCCT_A_PAFLG: rdata_d[1:0] = paflg_q;
                `FCCT_A_PACNT: rdata_d = pacnt_q;
                `FCCT_A_PORT: rdata_d[NCH-1:0] =
                    (ddr_q & port_q) | (~ddr_q & s2_q);
                `FCCT_A_DDR: rdata_d[NCH-1:0] = ddr_q;
                default: begin
                    for (int n = 0; n < NCH; n++) begin
                        if (i_addr == 5'(`FCCT_A_CMP0 + n)) begin
                            rdata_d = cmp_q[n];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_div_off;
        !en ##1 !en;
    endsequence

    capture_copy_a: assert property (cap[0] |=>
        cmp_q[0] == $past(cnt_q)) else $error("capture missed counter");
    chan_flag_a: assert property ((cap | match) != 0 |=>
        (flag_q & $past(cap | match)) == $past(cap | match))
        else $error("channel flag not set by event");
    force_flag_a: assert property (force_hit != 0 &&
        (cap | match) == 0 |=> flag_q == $past(flag_q))
        else $error("forced compare changed a flag");
    ch3_override_a: assert property (match[3] |=>
        ((oc_q ^ $past(c3dat_q)) & $past(mask_q & ios_q)) == 0)
        else $error("channel 3 did not override");
    port_xfer_a: assert property (match[3] |=>
        ((port_q ^ $past(c3dat_q)) & $past(mask_q)) == 0)
        else $error("masked port transfer missing");
    cnt_reset_a: assert property (match[3] && counter_reset_on_ch3 |=>
        cnt_q == 16'h0000) else $error("counter not reset by channel 3");
    pin_off_a: assert property (ios_q[1] && outctl_q[3:2] == 2'h0 &&
        !mask_q[1] |=> o_pin_oe[1] == $past(ddr_q[1]))
        else $error("disconnected pin still driven");
    pa_event_a: assert property (pa_edge && !pa_wr |=>
        pacnt_q == $past(pacnt_q) + 16'h0001 && paflg_q[0])
        else $error("event not counted");
    pa_wrap_a: assert property (pa_inc && !pa_wr &&
        pacnt_q == 16'hffff |=> pacnt_q == 16'h0000 && paflg_q[1])
        else $error("overflow not flagged");
    gate_stop_a: assert property (s_div_off ##0
        (pactl_q[`FCCT_PACTL_MODE] && !pa_wr) |=> pacnt_q == $past(pacnt_q))
        else $error("gated count moved with timer off");
    fast_clear_a: assert property (pa_touch && !pa_edge &&
        !pa_trail && !pa_inc |=> paflg_q == 2'h0)
        else $error("fast clear missed");
endmodule : fcct_timer

//--- bench/fcct_pin_model.sv
/*
 * Pad model of the four timer pins: resolves each wire from the timer's
 * drive and the outside source that the bench commands.
 * Assumes the outside source always drives, so no pin ever floats.
 */
`timescale 1ns/10ps

module fcct_pin_model (
    input wire logic [3:0] i_ext,
    input wire logic [3:0] i_pin_out,
    input wire logic [3:0] i_pin_oe,
    output logic [3:0] o_pad
);
    // Timer drive wins over the outside source on an enabled pin
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            o_pad[n] = i_pin_oe[n] ? i_pin_out[n] : i_ext[n];
        end
    end
endmodule : fcct_pin_model

//--- bench/tb_fcct_timer.sv
/*
 * Self-checking bench of the capture/compare timer, one task per scenario.
 * Assumes the register map of fcct_regs.svh and a 40 MHz clock.
 */
`timescale 1ns/10ps
`include "fcct_regs.svh"

module tb_fcct_timer;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic [3:0] ext = 4'h0;
    logic [3:0] pad;
    logic [3:0] o_pin_out;
    logic [3:0] o_pin_oe;
    logic [5:0] o_irq;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;

    fcct_timer i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_pin(pad), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_irq(o_irq));
    fcct_pin_model i_pins (.i_ext(ext), .i_pin_out(o_pin_out),
        .i_pin_oe(o_pin_oe), .o_pad(pad));

    // ------------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------------------------
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    // Hang guard, far above the roughly 1500 cycles the run needs
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic reset_dut();
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        ext <= 4'h0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
    endtask : reset_dut

    // One write cycle; a spare edge first keeps strobes from colliding
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the read edge
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    // Pulse on the shared channel-3 pin, five clocks each level
    task automatic pulse3();
        @(posedge i_clk);
        ext[3] <= 1'b1;
        repeat (5) @(posedge i_clk);
        ext[3] <= 1'b0;
        repeat (5) @(posedge i_clk);
    endtask : pulse3

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_and_prescale();
        logic [15:0] a;
        logic [15:0] b;
        int div;
        reset_dut();
        rd(`FCCT_A_COUNT, a);
        chk(a, 16'h0000, "count at reset");
        rd(5'h1f, a);
        chk(a, 16'h0000, "unmapped read");
        for (int k = 0; k < 8; k++) begin
            div = (k > 4) ? 16 : (1 << k);
            wr(`FCCT_A_CTRL, 16'((k << 4) | 1));
            rd(`FCCT_A_COUNT, a);
            repeat (62) @(posedge i_clk);
            rd(`FCCT_A_COUNT, b);
            chk(b - a, 16'(64 / div), "prescaled advance");
        end
    endtask : t_reset_and_prescale

    task automatic t_capture();
        logic [15:0] t;
        logic [15:0] c;
        reset_dut();
        wr(`FCCT_A_EDGE, 16'h0003);
        wr(`FCCT_A_IRQEN, 16'h0001);
        wr(`FCCT_A_CTRL, 16'h0001);
        rd(`FCCT_A_COUNT, t);
        @(posedge i_clk);
        ext[0] <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(`FCCT_A_CMP0, c);
        chk(16'(c - t > 16'h0 && c - t < 16'h9), 16'h1, "capture time");
        rd(`FCCT_A_FLAGS, c);
        chk(c, 16'h0001, "capture flag");
        chk(16'(o_irq), 16'h0001, "capture request");
        wr(`FCCT_A_FLAGS, 16'h0000);
        rd(`FCCT_A_FLAGS, c);
        chk(c, 16'h0001, "flag kept on zero");
        wr(`FCCT_A_FLAGS, 16'h0001);
        rd(`FCCT_A_FLAGS, c);
        chk(c, 16'h0000, "flag cleared by one");
        // Falling edge is enabled as well, so the release captures again
        @(posedge i_clk);
        ext[0] <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd(`FCCT_A_FLAGS, c);
        chk(c, 16'h0001, "falling capture");
    endtask : t_capture

    task automatic t_force_and_latch();
        fcct_pkg::fcct_act_t acts [4];
        logic [15:0] f;
        acts = '{fcct_pkg::FCCT_ACT_SET, fcct_pkg::FCCT_ACT_CLR,
                 fcct_pkg::FCCT_ACT_TGL, fcct_pkg::FCCT_ACT_TGL};
        reset_dut();
        wr(5'h0a, 16'h8000);
        wr(`FCCT_A_IOS, 16'h0002);
        wr(`FCCT_A_CTRL, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            wr(`FCCT_A_OUTCTL, 16'(acts[k]) << 2);
            wr(`FCCT_A_FORCE, 16'h0002);
            repeat (3) @(posedge i_clk);
            #1 chk(16'(o_pin_oe[1]), 16'h1, "driven, dir in");
            chk(16'(o_pin_out[1]), 16'(k % 2 == 0), "forced");
        end
        rd(`FCCT_A_FLAGS, f);
        chk(f, 16'h0000, "no flag on force");
        wr(`FCCT_A_PORT, 16'h0002);
        repeat (3) @(posedge i_clk);
        #1 chk(16'(o_pin_out[1]), 16'h0, "port write held back");
        wr(`FCCT_A_OUTCTL, 16'h0000);
        repeat (3) @(posedge i_clk);
        #1 chk(16'(o_pin_oe[1]), 16'h0, "pin disconnected");
        wr(`FCCT_A_DDR, 16'h0002);
        repeat (3) @(posedge i_clk);
        #1 chk(16'({o_pin_oe[1], o_pin_out[1]}), 16'h3, "latch out");
        // Real match on channel 1: toggle from 0 once the count hits 0x10
        wr(`FCCT_A_OUTCTL, 16'h0004);
        wr(`FCCT_A_COUNT, 16'h0000);
        wr(5'h0a, 16'h0010);
        repeat (30) @(posedge i_clk);
        #1 chk(16'(o_pin_out[1]), 16'h1, "match toggle");
        rd(`FCCT_A_FLAGS, f);
        chk(f, 16'h0002, "compare flag");
    endtask : t_force_and_latch

    task automatic t_ch3_compare();
        logic [15:0] v;
        reset_dut();
        wr(5'h0c, 16'h0040);
        wr(`FCCT_A_IOS, 16'h000c);
        wr(`FCCT_A_CH3, 16'h0044);
        wr(`FCCT_A_DDR, 16'h0004);
        wr(`FCCT_A_CTRL, 16'h0005);
        repeat (80) @(posedge i_clk);
        #1 chk(16'({o_pin_oe[2], o_pin_out[2]}), 16'h3, "ch3 wins");
        rd(`FCCT_A_PORT, v);
        chk(v & 16'h0004, 16'h0004, "masked transfer");
        rd(`FCCT_A_FLAGS, v);
        chk(v & 16'h0008, 16'h0008, "compare flag");
        repeat (200) @(posedge i_clk);
        rd(`FCCT_A_COUNT, v);
        chk(16'(v <= 16'h0041), 16'h1, "counter reset on ch3");
    endtask : t_ch3_compare

    task automatic t_accum_event();
        logic [15:0] v;
        reset_dut();
        // Channel-3 output bits and mask stay clear from reset
        // Falling edges counted; each pulse ends with one
        wr(`FCCT_A_PACTL, 16'h0004);
        wr(`FCCT_A_PACNT, 16'hfffe);
        wr(`FCCT_A_IRQEN, 16'h0030);
        pulse3();
        pulse3();
        rd(`FCCT_A_PACNT, v);
        chk(v, 16'h0000, "events counted, timer off");
        rd(`FCCT_A_PAFLG, v);
        chk(v, 16'h0003, "input and wrap flags");
        chk(16'(o_irq[5:4]), 16'h3, "accumulator requests");
        wr(`FCCT_A_PAFLG, 16'h0001);
        rd(`FCCT_A_PAFLG, v);
        chk(v, 16'h0002, "one flag cleared");
        wr(`FCCT_A_CTRL, 16'h0002);
        rd(`FCCT_A_PACNT, v);
        rd(`FCCT_A_PAFLG, v);
        chk(v, 16'h0000, "fast clear on access");
    endtask : t_accum_event

    task automatic t_accum_gated();
        logic [15:0] v;
        reset_dut();
        wr(`FCCT_A_PACTL, 16'h0007);
        ext[3] <= 1'b1;
        repeat (200) @(posedge i_clk);
        rd(`FCCT_A_PACNT, v);
        chk(v, 16'h0000, "no gate clock, timer off");
        @(posedge i_clk);
        ext[3] <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd(`FCCT_A_PAFLG, v);
        chk(v, 16'h0001, "trailing edge flag");
        wr(`FCCT_A_PAFLG, 16'h0001);
        wr(`FCCT_A_CTRL, 16'h0001);
        ext[3] <= 1'b1;
        repeat (256) @(posedge i_clk);
        ext[3] <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd(`FCCT_A_PACNT, v);
        chk(16'(v >= 16'h3 && v <= 16'h5), 16'h1, "gated count");
    endtask : t_accum_gated

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        t_reset_and_prescale();
        t_capture();
        t_force_and_latch();
        t_ch3_compare();
        t_accum_event();
        t_accum_gated();
        finish_test();
    end
endmodule : tb_fcct_timer
